// *** include/cnm_defs.vh ***
`ifndef CNM_DEFS_VH
`define CNM_DEFS_VH
// Function codes of the default identifier set.
`define CNM_FC_NMT      4'h0
`define CNM_FC_SYNC     4'h1
`define CNM_FC_EMCY     4'h1
`define CNM_FC_TIME     4'h2
`define CNM_FC_TPDO1    4'h3
`define CNM_FC_RPDO1    4'h4
`define CNM_FC_TPDO2    4'h5
`define CNM_FC_RPDO2    4'h6
`define CNM_FC_TPDO3    4'h7
`define CNM_FC_RPDO3    4'h8
`define CNM_FC_TPDO4    4'h9
`define CNM_FC_RPDO4    4'ha
`define CNM_FC_TSDO     4'hb
`define CNM_FC_RSDO     4'hc
`define CNM_FC_ERRCTL   4'he
// Identifier field positions.
`define CNM_ID_FC_HI    10
`define CNM_ID_FC_LO    7
`define CNM_ID_NODE_HI  6
`define CNM_ID_NODE_LO  0
// Command specifiers carried in byte 0 of an NMT frame.
`define CNM_CS_START    8'h01
`define CNM_CS_STOP     8'h02
`define CNM_CS_PREOP    8'h80
`define CNM_CS_RST_NODE 8'h81
`define CNM_CS_RST_COMM 8'h82
// State codes reported in heartbeat and guarding answers.
`define CNM_RPT_BOOT    7'h00
`define CNM_RPT_STOP    7'h04
`define CNM_RPT_OPER    7'h05
`define CNM_RPT_PREOP   7'h7f
// Millisecond tick: 1 ms at 50 MHz.
`define CNM_CLK_HZ      50000000
`define CNM_TICK_MS     1
`define CNM_TICK_CYC    (`CNM_CLK_HZ / 1000 * `CNM_TICK_MS)
// Reset values of the configured times.
`define CNM_RST_TIME    16'h0000
`endif

// *** hw/cnm_id_filter.v ***
`timescale 1ns/1ns
`include "cnm_defs.vh"
// Classifies one received identifier against the default connection set.
module cnm_id_filter (
  // Received frame identifier and own node.
  input  wire [10:0] i_id,
  input  wire [6:0]  i_node_id,
  // Configured receive identifiers for the four receive PDOs.
  input  wire [43:0] i_rpdo_id,
  // Classification.
  output wire        o_is_nmt,
  output wire        o_is_sync,
  output wire        o_is_rsdo,
  output wire        o_is_guard,
  output wire        o_is_hb,
  output wire [3:0]  o_rpdo_hit
);

  wire [3:0] fc;
  wire [6:0] nid;

  // Split the identifier into function and node parts.
  assign fc  = i_id[`CNM_ID_FC_HI:`CNM_ID_FC_LO];
  assign nid = i_id[`CNM_ID_NODE_HI:`CNM_ID_NODE_LO];

  // Broadcast objects carry node zero; fixed peer objects carry our node.
  assign o_is_nmt   = (fc == `CNM_FC_NMT) && (nid == 7'h00);
  assign o_is_sync  = (fc == `CNM_FC_SYNC) && (nid == 7'h00);
  assign o_is_rsdo  = (fc == `CNM_FC_RSDO) && (nid == i_node_id);
  assign o_is_guard = (fc == `CNM_FC_ERRCTL) && (nid == i_node_id);
  // Heartbeats of any other node may be monitored.
  assign o_is_hb    = (fc == `CNM_FC_ERRCTL) && (nid != 7'h00) &&
                      (nid != i_node_id);

  // Receive PDOs match whatever identifier is configured for them.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_rpdo
      assign o_rpdo_hit[g] = (i_id == i_rpdo_id[g*11+10:g*11]);
    end
  endgenerate

endmodule // cnm_id_filter

// *** hw/cnm_nmt_slave.v ***
`timescale 1ns/1ns
`include "cnm_defs.vh"
module cnm_nmt_slave (
  // Clock and reset.
  input  wire        i_core_clk,
  input  wire        i_rst,
  // Node configuration, steady while running.
  input  wire [6:0]  i_node_id,
  input  wire        i_has_storage,
  input  wire [15:0] i_hb_prod_ms,
  input  wire [15:0] i_hb_cons_ms,
  input  wire [15:0] i_life_ms,
  input  wire [43:0] i_rpdo_id_cfg,
  input  wire [3:0]  i_rpdo_id_set,
  // Received frame.
  input  wire        i_rx_valid,
  input  wire [10:0] i_rx_id,
  input  wire        i_rx_rtr,
  input  wire [3:0]  i_rx_dlc,
  input  wire [7:0]  i_rx_b0,
  input  wire [7:0]  i_rx_b1,
  // Transmit request, held until accepted.
  input  wire        i_tx_ready,
  output reg         o_tx_valid,
  output reg  [10:0] o_tx_id,
  output reg  [3:0]  o_tx_dlc,
  output reg  [7:0]  o_tx_b0,
  // Application and status.
  output reg         o_load_app,
  output reg         o_load_comm,
  output reg         o_load_stored,
  output reg         o_load_default,
  output reg  [6:0]  o_state,
  output reg         o_pdo_en,
  output reg         o_sdo_en,
  output reg  [3:0]  o_rpdo_accept,
  output reg         o_sdo_accept,
  output reg         o_sync_accept,
  output reg         o_hb_event,
  output reg         o_life_event,
  output reg         o_guard_active,
  output reg         o_hb_active,
  output reg  [43:0] o_rpdo_id
);

  // One-hot node states.
  localparam ST_RST_APP  = 7'h01;
  localparam ST_RST_COMM = 7'h02;
  localparam ST_INIT     = 7'h04;
  localparam ST_BOOT     = 7'h08;
  localparam ST_PREOP    = 7'h10;
  localparam ST_OPER     = 7'h20;
  localparam ST_STOP     = 7'h40;

  reg  [6:0]  state;
  reg  [6:0]  next_state;
  reg         from_comm;
  reg  [15:0] tick_cnt;
  reg         tick;
  reg  [15:0] hb_prod_cnt;
  reg  [15:0] hb_cons_cnt;
  reg  [15:0] life_cnt;
  reg  [1:0]  toggle;
  reg         guard_pend;
  reg         hb_pend;
  wire        is_nmt;
  wire        is_sync;
  wire        is_rsdo;
  wire        is_guard;
  wire        is_hb;
  wire [3:0]  rpdo_hit;
  wire        for_us;
  wire        cmd_ok;
  wire        tx_take;
  wire [31:0] tick_last;
  reg  [6:0]  rpt;

  // Identifier classifier.
  cnm_id_filter u_filter (
    .i_id       (i_rx_id),
    .i_node_id  (i_node_id),
    .i_rpdo_id  (o_rpdo_id),
    .o_is_nmt   (is_nmt),
    .o_is_sync  (is_sync),
    .o_is_rsdo  (is_rsdo),
    .o_is_guard (is_guard),
    .o_is_hb    (is_hb),
    .o_rpdo_hit (rpdo_hit)
  );

  // Node zero in byte 1 addresses every node at once.
  assign for_us  = (i_rx_b1 == 8'h00) || (i_rx_b1 == {1'b0, i_node_id});
  assign cmd_ok  = i_rx_valid && is_nmt && !i_rx_rtr &&
                   (i_rx_dlc == 4'h2) && for_us;
  assign tx_take = o_tx_valid && i_tx_ready;
  // Last count of the millisecond divider, cut to the counter's width.
  assign tick_last = `CNM_TICK_CYC - 1;

  // Code of the present state as reported on the bus.
  always @* begin
    case (state)
      ST_STOP:  rpt = `CNM_RPT_STOP;
      ST_OPER:  rpt = `CNM_RPT_OPER;
      ST_PREOP: rpt = `CNM_RPT_PREOP;
      default:  rpt = `CNM_RPT_BOOT;
    endcase
  end

  // Next node state; commands are honoured in every running state.
  always @* begin
    next_state = state;
    case (state)
      ST_RST_APP:  next_state = ST_RST_COMM;
      ST_RST_COMM: next_state = ST_INIT;
      ST_INIT:     next_state = ST_BOOT;
      ST_BOOT: begin
        if (tx_take) begin
          next_state = ST_PREOP;
        end
      end
      ST_PREOP, ST_OPER, ST_STOP: begin
        if (cmd_ok) begin
          case (i_rx_b0)
            `CNM_CS_START:    next_state = ST_OPER;
            `CNM_CS_STOP:     next_state = ST_STOP;
            `CNM_CS_PREOP:    next_state = ST_PREOP;
            `CNM_CS_RST_NODE: next_state = ST_RST_APP;
            `CNM_CS_RST_COMM: next_state = ST_RST_COMM;
            default:          next_state = state;
          endcase
        end
      end
      default: next_state = ST_RST_APP;
    endcase
  end

  // State register and the one-cycle load strobes of initialisation.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state          <= ST_RST_APP;
      from_comm      <= 1'b0;
      o_load_app     <= 1'b0;
      o_load_comm    <= 1'b0;
      o_load_stored  <= 1'b0;
      o_load_default <= 1'b0;
    end else begin
      state          <= next_state;
      o_load_app     <= (state == ST_RST_APP);
      o_load_comm    <= (state == ST_RST_COMM);
      // Only a reset-communication command skips the stored values; the
      // power-on and reset-node paths pass reset-application first.
      if (state == ST_RST_APP) begin
        from_comm <= 1'b0;
      end else if (next_state == ST_RST_COMM) begin
        from_comm <= 1'b1;
      end
      o_load_stored  <= (state == ST_INIT) && !from_comm &&
                        i_has_storage;
      o_load_default <= (state == ST_INIT) && !from_comm &&
                        !i_has_storage;
    end
  end

  // Default function code of receive PDO n: 4, 6, 8 and 10.
  function [3:0] rpdo_fc;
    input integer idx;
    begin
      rpdo_fc = `CNM_FC_RPDO1 + {idx[1:0], 1'b0};
    end
  endfunction

  // Identifier table: reset-communication restores the default set.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_id
      always @(posedge i_core_clk) begin
        if (i_rst || state == ST_RST_COMM) begin
          o_rpdo_id[g*11+10:g*11] <= {rpdo_fc(g), 7'h00};
        end else if (state == ST_INIT) begin
          // Default receive identifiers carry our node.
          o_rpdo_id[g*11+10:g*11] <= {rpdo_fc(g), i_node_id};
        end else if (state == ST_PREOP && i_rpdo_id_set[g]) begin
          // Only PDO identifiers are writable; the rest stay fixed.
          o_rpdo_id[g*11+10:g*11] <= i_rpdo_id_cfg[g*11+10:g*11];
        end
      end
    end
  endgenerate

  // Traffic gating and receive acceptance, one cycle after the frame.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_state       <= `CNM_RPT_BOOT;
      o_pdo_en      <= 1'b0;
      o_sdo_en      <= 1'b0;
      o_rpdo_accept <= 4'h0;
      o_sdo_accept  <= 1'b0;
      o_sync_accept <= 1'b0;
    end else begin
      o_state       <= rpt;
      o_pdo_en      <= (state == ST_OPER);
      o_sdo_en      <= (state == ST_OPER) || (state == ST_PREOP);
      o_rpdo_accept <= (i_rx_valid && !i_rx_rtr && state == ST_OPER) ?
                       rpdo_hit : 4'h0;
      o_sdo_accept  <= i_rx_valid && !i_rx_rtr && is_rsdo &&
                       ((state == ST_OPER) || (state == ST_PREOP));
      o_sync_accept <= i_rx_valid && is_sync && (state == ST_OPER);
    end
  end

  // Millisecond tick from a divider.
  always @(posedge i_core_clk) begin
    if (i_rst || tick_cnt == tick_last[15:0]) begin
      tick_cnt <= 16'h0000;
      tick     <= ~i_rst;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // Error-control selection: first service started after boot-up wins.
  always @(posedge i_core_clk) begin
    if (i_rst || state == ST_RST_APP || state == ST_RST_COMM) begin
      o_hb_active    <= 1'b0;
      o_guard_active <= 1'b0;
    end else if (!o_hb_active && !o_guard_active &&
                 (state == ST_PREOP || state == ST_OPER ||
                  state == ST_STOP)) begin
      if (i_hb_prod_ms != `CNM_RST_TIME) begin
        o_hb_active <= 1'b1;
      end else if (i_rx_valid && is_guard && i_rx_rtr) begin
        o_guard_active <= 1'b1;
      end
    end
  end

  // Heartbeat producer period in ms; a new period outranks the take that
  // clears the pending flag, so no period is lost or drifts.
  always @(posedge i_core_clk) begin
    if (i_rst || !o_hb_active) begin
      hb_prod_cnt <= 16'h0000;
      hb_pend     <= 1'b0;
    end else begin
      if (tick && hb_prod_cnt + 16'h0001 >= i_hb_prod_ms) begin
        hb_prod_cnt <= 16'h0000;
        hb_pend     <= 1'b1;
      end else begin
        if (tick) begin
          hb_prod_cnt <= hb_prod_cnt + 16'h0001;
        end
        if (tx_take && !guard_pend) begin
          hb_pend <= 1'b0;
        end
      end
    end
  end

  // Consumer: restarts on each monitored heartbeat, zero time disables.
  always @(posedge i_core_clk) begin
    if (i_rst || i_hb_cons_ms == `CNM_RST_TIME) begin
      hb_cons_cnt <= 16'h0000;
      o_hb_event  <= 1'b0;
    end else if (i_rx_valid && is_hb && !i_rx_rtr) begin
      hb_cons_cnt <= 16'h0000;
      o_hb_event  <= 1'b0;
    end else if (tick && !o_hb_event) begin
      if (hb_cons_cnt + 16'h0001 >= i_hb_cons_ms) begin
        o_hb_event <= 1'b1;
      end else begin
        hb_cons_cnt <= hb_cons_cnt + 16'h0001;
      end
    end
  end

  // Life guarding: each poll restarts the life timer.
  always @(posedge i_core_clk) begin
    if (i_rst || !o_guard_active || i_life_ms == `CNM_RST_TIME) begin
      life_cnt     <= 16'h0000;
      o_life_event <= 1'b0;
    end else if (i_rx_valid && is_guard && i_rx_rtr) begin
      life_cnt     <= 16'h0000;
      o_life_event <= 1'b0;
    end else if (tick && !o_life_event) begin
      if (life_cnt + 16'h0001 >= i_life_ms) begin
        o_life_event <= 1'b1;
      end else begin
        life_cnt <= life_cnt + 16'h0001;
      end
    end
  end

  // Guard answers; a poll arriving during acceptance is still kept.
  always @(posedge i_core_clk) begin
    if (i_rst || state == ST_RST_APP || state == ST_RST_COMM) begin
      guard_pend <= 1'b0;
      toggle     <= 2'b00;
    end else begin
      if (i_rx_valid && is_guard && i_rx_rtr &&
          (o_guard_active || i_hb_prod_ms == `CNM_RST_TIME)) begin
        guard_pend <= 1'b1;
      end else if (tx_take && guard_pend) begin
        guard_pend <= 1'b0;
      end
      if (tx_take && guard_pend) begin
        toggle <= {1'b0, ~toggle[0]};
      end
    end
  end

  // Transmit slot: boot-up first, then guard answers, then heartbeats.
  // All frames use the fixed error-control identifier of this node.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_id    <= 11'h000;
      o_tx_dlc   <= 4'h0;
      o_tx_b0    <= 8'h00;
    end else if (o_tx_valid && !i_tx_ready) begin
      o_tx_valid <= 1'b1;  // Held until accepted, so no frame is lost.
    end else if (state == ST_BOOT && !tx_take) begin
      o_tx_valid <= 1'b1;
      o_tx_id    <= {`CNM_FC_ERRCTL, i_node_id};
      o_tx_dlc   <= 4'h1;
      o_tx_b0    <= {1'b0, `CNM_RPT_BOOT};
    end else if (guard_pend && !tx_take) begin
      o_tx_valid <= 1'b1;
      o_tx_id    <= {`CNM_FC_ERRCTL, i_node_id};
      o_tx_dlc   <= 4'h1;
      o_tx_b0    <= {toggle[0], rpt};
    end else if (hb_pend && !tx_take) begin
      o_tx_valid <= 1'b1;
      o_tx_id    <= {`CNM_FC_ERRCTL, i_node_id};
      o_tx_dlc   <= 4'h1;
      o_tx_b0    <= {1'b0, rpt};
    end else begin
      o_tx_valid <= 1'b0;
    end
  end

endmodule // cnm_nmt_slave

// *** bench/cnm_master_model.sv ***
`timescale 1ns/1ns
// Master on the far side: offers frames and takes the node's answers.
module cnm_master_model (
  // Clock and pace.
  input  wire        i_core_clk,
  input  wire        i_slow,
  // Frame offered to the node.
  output reg         o_rx_valid,
  output reg  [10:0] o_rx_id,
  output reg         o_rx_rtr,
  output reg  [3:0]  o_rx_dlc,
  output reg  [7:0]  o_rx_b0,
  output reg  [7:0]  o_rx_b1,
  // Answer taken from the node.
  output reg         o_tx_ready,
  input  wire        i_tx_valid,
  input  wire [10:0] i_tx_id,
  input  wire [7:0]  i_tx_b0
);
  integer    tx_count = 0;
  reg [10:0] last_id  = 11'h000;
  reg [7:0]  last_b0  = 8'h00;

  // Lines start idle so the node sees no frame before reset ends.
  initial begin
    o_rx_valid = 1'b0;
    {o_rx_id, o_rx_rtr, o_rx_dlc, o_rx_b0, o_rx_b1} = 32'h0;
    o_tx_ready = 1'b0;
  end

  // A slow master takes an answer only every other cycle.
  always @(negedge i_core_clk) begin
    o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
  end

  // An answer counts as taken on the edge that sees valid and ready.
  always @(posedge i_core_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      tx_count <= tx_count + 1;
      last_id  <= i_tx_id;
      last_b0  <= i_tx_b0;
    end
  end

  // One frame for exactly one edge; after it the identifier and data lines carry inverted values
  // (rtr and dlc keep theirs) so a stale value is never mistaken for a frame.
  task send(input [10:0] id, input rtr, input [3:0] dlc, input [7:0] b0,
            input [7:0] b1);
    begin
      @(negedge i_core_clk);
      o_rx_valid = 1'b1;
      {o_rx_id, o_rx_rtr, o_rx_dlc, o_rx_b0, o_rx_b1} =
        {id, rtr, dlc, b0, b1};
      @(negedge i_core_clk);
      o_rx_valid = 1'b0;
      {o_rx_id, o_rx_b0, o_rx_b1} = ~{o_rx_id, o_rx_b0, o_rx_b1};
    end
  endtask
endmodule // cnm_master_model

// *** bench/cnm_nmt_slave_properties.sv ***
`timescale 1ns/1ns
`include "cnm_defs.vh"
// Watches state, filter and answer relations at the slave's ports.
module cnm_nmt_slave_properties (
  // Clock, reset and configuration.
  input wire        i_core_clk,
  input wire        i_rst,
  input wire [6:0]  i_node_id,
  input wire [15:0] i_hb_prod_ms,
  // Received frame.
  input wire        i_rx_valid,
  input wire [10:0] i_rx_id,
  input wire        i_rx_rtr,
  input wire [3:0]  i_rx_dlc,
  input wire [7:0]  i_rx_b0,
  input wire [7:0]  i_rx_b1,
  // Transmit side and status.
  input wire        i_tx_ready,
  input wire        o_tx_valid,
  input wire [10:0] o_tx_id,
  input wire [7:0]  o_tx_b0,
  input wire [6:0]  o_state,
  input wire        o_pdo_en,
  input wire        o_sdo_en,
  input wire [3:0]  o_rpdo_accept,
  input wire        o_sync_accept
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire [10:0] ec_id = {`CNM_FC_ERRCTL, i_node_id};
  // A well-formed NMT frame for us, outside initialisation.
  wire nmt = i_rx_valid && !i_rx_rtr && i_rx_id == 11'h000 &&
             i_rx_dlc == 4'h2 && o_state != `CNM_RPT_BOOT &&
             (i_rx_b1 == 8'h00 || i_rx_b1 == {1'b0, i_node_id});
  sequence s_poll;
    i_rx_valid && i_rx_rtr && i_rx_id == ec_id && i_hb_prod_ms == 16'h0;
  endsequence
  sequence s_reply;
    o_tx_valid && o_tx_id == ec_id && o_tx_b0[6:0] == o_state;
  endsequence
  sequence s_boot;
    o_tx_valid && o_tx_id == ec_id && o_tx_b0 == 8'h00;
  endsequence

  // The state register and then the reported code follow a command, so
  // the code shows the new state two edges after the frame.
  chk_boot_frame: assert property (
      $fell(i_rst) |-> ##[0:30] s_boot)
    else $error("boot-up frame missing");
  chk_cmd_start: assert property (
      nmt && i_rx_b0 == `CNM_CS_START |-> ##2 o_state == `CNM_RPT_OPER)
    else $error("start not obeyed");
  chk_cmd_stop: assert property (
      nmt && i_rx_b0 == `CNM_CS_STOP |-> ##2 o_state == `CNM_RPT_STOP)
    else $error("stop not obeyed");
  chk_cmd_preop: assert property (
      nmt && i_rx_b0 == `CNM_CS_PREOP |-> ##2 o_state == `CNM_RPT_PREOP)
    else $error("pre-operational not obeyed");
  chk_stop_quiet: assert property (
      (o_state == `CNM_RPT_STOP)[*2] |-> !o_pdo_en && !o_sdo_en)
    else $error("traffic open while stopped");
  chk_oper_open: assert property (
      (o_state == `CNM_RPT_OPER)[*2] |-> o_pdo_en && o_sdo_en)
    else $error("traffic shut while operational");
  chk_preop_sdo: assert property (
      (o_state == `CNM_RPT_PREOP)[*2] |-> !o_pdo_en && o_sdo_en)
    else $error("wrong traffic in pre-operational");
  chk_rpdo_shut: assert property (
      i_rx_valid && o_state != `CNM_RPT_OPER |=> o_rpdo_accept == 4'h0)
    else $error("process data taken outside operational");
  chk_sync_take: assert property (
      i_rx_valid && !i_rx_rtr && i_rx_id == 11'h080 &&
      o_state == `CNM_RPT_OPER |=> o_sync_accept)
    else $error("sync frame not taken");
  chk_guard_reply: assert property (
      s_poll |-> ##[1:8] s_reply)
    else $error("guard poll not answered");
  chk_tx_hold: assert property (
      o_tx_valid && !i_tx_ready |=>
      o_tx_valid && $stable(o_tx_id) && $stable(o_tx_b0))
    else $error("answer dropped before taken");
endmodule // cnm_nmt_slave_properties

bind cnm_nmt_slave cnm_nmt_slave_properties u_chk (.i_core_clk, .i_rst,
  .i_node_id, .i_hb_prod_ms, .i_rx_valid, .i_rx_id, .i_rx_rtr, .i_rx_dlc,
  .i_rx_b0, .i_rx_b1, .i_tx_ready, .o_tx_valid, .o_tx_id, .o_tx_b0,
  .o_state, .o_pdo_en, .o_sdo_en, .o_rpdo_accept, .o_sync_accept);

// *** bench/tb_canopen_nmt_slave_control.sv ***
`timescale 1ns/1ns
`include "cnm_defs.vh"
// Drives the slave through a master model and judges every answer.
module tb_canopen_nmt_slave_control;
  localparam [6:0] NODE = 7'h25;
  reg         i_core_clk = 1'b0;
  reg         i_rst      = 1'b1;
  reg         slow       = 1'b0;
  reg  [43:0] rpdo_cfg   = 44'h0;
  reg  [3:0]  rpdo_set   = 4'h0;
  reg         storage    = 1'b1;
  reg         clr_req    = 1'b0;
  reg         seen_app, seen_comm, seen_stored, seen_def, seen_sdo, seen_sync;
  reg  [3:0]  seen_rpdo;
  integer     mismatches = 0;
  integer     checks     = 0;
  wire        rx_valid, rx_rtr, tx_valid, tx_ready, load_app, load_comm;
  wire        load_stored, pdo_en, sdo_en, sdo_acc, sync_acc, guard_act;
  wire        hb_act, load_def;
  wire [10:0] rx_id, tx_id;
  wire [3:0]  rx_dlc, rpdo_acc;
  wire [7:0]  rx_b0, rx_b1, tx_b0;
  wire [6:0]  state;
  wire [43:0] rpdo_id;

  // Free-running 50 MHz clock.
  always #10 i_core_clk = ~i_core_clk;

  cnm_master_model model (.i_core_clk(i_core_clk), .i_slow(slow),
    .o_rx_valid(rx_valid), .o_rx_id(rx_id), .o_rx_rtr(rx_rtr),
    .o_rx_dlc(rx_dlc), .o_rx_b0(rx_b0), .o_rx_b1(rx_b1),
    .o_tx_ready(tx_ready), .i_tx_valid(tx_valid), .i_tx_id(tx_id),
    .i_tx_b0(tx_b0));

  cnm_nmt_slave dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_node_id(NODE), .i_has_storage(storage), .i_hb_prod_ms(16'h0000),
    .i_hb_cons_ms(16'h0000), .i_life_ms(16'h0000), .i_rpdo_id_cfg(rpdo_cfg),
    .i_rpdo_id_set(rpdo_set), .i_rx_valid(rx_valid), .i_rx_id(rx_id),
    .i_rx_rtr(rx_rtr), .i_rx_dlc(rx_dlc), .i_rx_b0(rx_b0), .i_rx_b1(rx_b1),
    .i_tx_ready(tx_ready), .o_tx_valid(tx_valid), .o_tx_id(tx_id),
    .o_tx_dlc(), .o_tx_b0(tx_b0), .o_load_app(load_app),
    .o_load_comm(load_comm), .o_load_stored(load_stored),
    .o_load_default(load_def), .o_state(state), .o_pdo_en(pdo_en),
    .o_sdo_en(sdo_en), .o_rpdo_accept(rpdo_acc), .o_sdo_accept(sdo_acc),
    .o_sync_accept(sync_acc), .o_hb_event(), .o_life_event(),
    .o_guard_active(guard_act), .o_hb_active(hb_act), .o_rpdo_id(rpdo_id));

  // Pulses are one cycle wide, so they are caught in sticky flags.
  always @(posedge i_core_clk) begin
    if (clr_req) begin
      {seen_app, seen_comm, seen_stored, seen_def, seen_sdo} <= 5'h00;
      {seen_sync, seen_rpdo} <= 5'h00;
    end else begin
      seen_app    <= seen_app | load_app;
      seen_comm   <= seen_comm | load_comm;
      seen_stored <= seen_stored | load_stored;
      seen_def    <= seen_def | load_def;
      seen_sdo    <= seen_sdo | sdo_acc;
      seen_sync   <= seen_sync | sync_acc;
      seen_rpdo   <= seen_rpdo | rpdo_acc;
    end
  end

  task check(input [43:0] seen, input [43:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // The flags are cleared by their own process, so they keep one driver.
  task clr;
    begin
      clr_req = 1'b1;
      @(negedge i_core_clk);
      clr_req = 1'b0;
    end
  endtask

  // Waits a bounded time for the next answer frame, then checks its id.
  task expect_tx(input integer n0, input [10:0] id);
    integer k;
    begin
      k = 0;
      while (model.tx_count == n0 && k < 60) begin
        @(negedge i_core_clk);
        k = k + 1;
      end
      check(model.tx_count > n0, 1'b1);
      check(model.last_id, id);
      repeat (3) @(negedge i_core_clk);
    end
  endtask

  task nmt(input [7:0] cmd, input [6:0] dst, input [3:0] dlc,
           input [6:0] st, input pdo, input sdo);
    begin
      model.send(11'h000, 1'b0, dlc, cmd, {1'b0, dst});
      repeat (3) @(negedge i_core_clk);
      check(state, st);
      check({pdo_en, sdo_en}, {pdo, sdo});
    end
  endtask

  // Power-on path, and the two reset commands that re-enter it.
  task t_boot(input [7:0] cmd);
    integer n0;
    begin
      clr;
      n0 = model.tx_count;
      if (cmd == 8'h00)
        i_rst = 1'b0;
      else
        model.send(11'h000, 1'b0, 4'h2, cmd, 8'h00);
      expect_tx(n0, {`CNM_FC_ERRCTL, NODE});
      check(model.last_b0, `CNM_RPT_BOOT);
      check(state, `CNM_RPT_PREOP);
      check(seen_app, cmd != `CNM_CS_RST_COMM);
      check(seen_comm, 1'b1);
      // Stored or default values load unless reset-communication was asked.
      check({seen_stored, seen_def},
            {storage, !storage} & {2{cmd != `CNM_CS_RST_COMM}});
    end
  endtask

  // Polls answered with the state and an alternating toggle, stopped too.
  task t_guard;
    integer n0;
    reg     tog;
    begin
      slow = 1'b1;
      n0 = model.tx_count;
      model.send({`CNM_FC_ERRCTL, NODE}, 1'b1, 4'h0, 8'h00, 8'h00);
      expect_tx(n0, {`CNM_FC_ERRCTL, NODE});
      check(model.last_b0[6:0], `CNM_RPT_PREOP);
      check({guard_act, hb_act}, 2'b10);
      tog = model.last_b0[7];
      nmt(`CNM_CS_STOP, NODE, 4'h2, `CNM_RPT_STOP, 1'b0, 1'b0);
      model.send({`CNM_FC_ERRCTL, NODE}, 1'b1, 4'h0, 8'h00, 8'h00);
      expect_tx(n0 + 1, {`CNM_FC_ERRCTL, NODE});
      check(model.last_b0, {~tog, `CNM_RPT_STOP});
      slow = 1'b0;
    end
  endtask

  // Identifier filtering by state, plus a remapped receive PDO.
  task t_filter;
    begin
      nmt(`CNM_CS_PREOP, 7'h00, 4'h2, `CNM_RPT_PREOP, 1'b0, 1'b1);
      clr;
      model.send({`CNM_FC_RSDO, NODE + 7'h01}, 1'b0, 4'h8, 8'h40, 8'h00);
      model.send({`CNM_FC_RPDO1, NODE}, 1'b0, 4'h1, 8'h11, 8'h00);
      repeat (3) @(negedge i_core_clk);
      check({seen_sdo, seen_rpdo}, 5'h00);
      model.send({`CNM_FC_RSDO, NODE}, 1'b0, 4'h8, 8'h40, 8'h00);
      model.send({`CNM_FC_SYNC, 7'h00}, 1'b0, 4'h0, 8'h00, 8'h00);
      repeat (3) @(negedge i_core_clk);
      // Sync is only taken while operational.
      check({seen_sdo, seen_sync}, 2'b10);
      rpdo_cfg[10:0] = 11'h1a5;
      rpdo_set = 4'h1;
      @(negedge i_core_clk);
      rpdo_set = 4'h0;
      repeat (2) @(negedge i_core_clk);
      check(rpdo_id[10:0], 11'h1a5);
      nmt(`CNM_CS_START, NODE, 4'h2, `CNM_RPT_OPER, 1'b1, 1'b1);
      clr;
      model.send(11'h1a5, 1'b0, 4'h1, 8'h22, 8'h00);
      model.send({`CNM_FC_RPDO2, NODE}, 1'b0, 4'h1, 8'h33, 8'h00);
      model.send({`CNM_FC_RPDO1, NODE}, 1'b0, 4'h1, 8'h44, 8'h00);
      model.send({`CNM_FC_SYNC, 7'h00}, 1'b0, 4'h0, 8'h00, 8'h00);
      repeat (3) @(negedge i_core_clk);
      check({seen_rpdo, seen_sync}, 5'h07);
      nmt(`CNM_CS_STOP, 7'h00, 4'h2, `CNM_RPT_STOP, 1'b0, 1'b0);
      clr;
      model.send({`CNM_FC_RSDO, NODE}, 1'b0, 4'h8, 8'h40, 8'h00);
      repeat (3) @(negedge i_core_clk);
      check(seen_sdo, 1'b0);
    end
  endtask

  task results;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Main sequence: reset held six cycles, then each scenario in turn.
  initial begin
    repeat (5) @(negedge i_core_clk);
    t_boot(8'h00);
    t_guard;
    nmt(`CNM_CS_START, NODE, 4'h2, `CNM_RPT_OPER, 1'b1, 1'b1);
    nmt(`CNM_CS_STOP, NODE + 7'h01, 4'h2, `CNM_RPT_OPER, 1'b1, 1'b1);
    nmt(`CNM_CS_STOP, NODE, 4'h3, `CNM_RPT_OPER, 1'b1, 1'b1);
    nmt(`CNM_CS_PREOP, NODE, 4'h2, `CNM_RPT_PREOP, 1'b0, 1'b1);
    nmt(`CNM_CS_START, 7'h00, 4'h2, `CNM_RPT_OPER, 1'b1, 1'b1);
    t_filter;
    // A node without parameter storage falls back to profile defaults.
    storage = 1'b0;
    t_boot(`CNM_CS_RST_NODE);
    t_boot(`CNM_CS_RST_COMM);
    results;
  end

  // A hang is cut short at 5000 cycles, well past the 150 or so that a clean run needs.
  initial begin
    repeat (5000) @(posedge i_core_clk);
    mismatches = mismatches + 1;
    results;
  end
endmodule // tb_canopen_nmt_slave_control
